// *** hw/uhie_defines.vh ***
`ifndef UHIE_DEFINES_VH
`define UHIE_DEFINES_VH

// Register byte addresses.
`define UHIE_STATUS_ADDR 12'h014
`define UHIE_INTR_EN_ADDR 12'h018
`define UHIE_FRAME_INDEX_ADDR 12'h01c
`define UHIE_PLIST_BASE_ADDR 12'h024
`define UHIE_CONTROL_ADDR 12'h040

// Event bit positions, shared by status and enable registers.
`define UHIE_EV_XFER_DONE 0
`define UHIE_EV_XFER_ERR 1
`define UHIE_EV_PORT_CHG 2
`define UHIE_EV_ROLLOVER 3
`define UHIE_EV_SYS_ERR 4
`define UHIE_EV_ASYNC_ADV 5
`define UHIE_EV_COUNT 6

// Status register: halted flag position.
`define UHIE_HALTED_BIT 12

// Control register fields.
`define UHIE_CTL_RUN_BIT 0
`define UHIE_CTL_SIZE_LSB 2
`define UHIE_CTL_THR_LSB 16
`define UHIE_CTL_THR_W 8

// List size codes.
`define UHIE_SIZE_1024 2'b00
`define UHIE_SIZE_512 2'b01
`define UHIE_SIZE_256 2'b10

// Field widths and reset values.
`define UHIE_FRAME_INDEX_W 14
`define UHIE_BASE_LSB 12
`define UHIE_THR_RESET 8'h08
`define UHIE_ENABLE_RESET 6'h00
`define UHIE_FRAME_INDEX_RESET 14'h0000
`define UHIE_BASE_RESET 20'h00000
`define UHIE_RUN_RESET 1'b0

// Micro-frame timing.
`define UHIE_UFRAME_NS 125000
`define UHIE_CLOCK_NS 5
`define UHIE_UFRAME_CYCLES (`UHIE_UFRAME_NS / `UHIE_CLOCK_NS)

`endif

// *** hw/uhie_event_flag.v ***
`timescale 1ns/10ps
`include "uhie_defines.vh"

module uhie_event_flag (
  input wire clock,
  input wire rst_b,
  input wire setEvent,
  input wire clearEvent,
  output reg flag
);

  // A set arriving with the clear wins so no event is lost.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (setEvent) begin
      flag <= 1'b1;
    end else if (clearEvent) begin
      flag <= 1'b0;
    end
  end

endmodule

// *** hw/uhie_regs.v ***
// Behaviour
// - Interrupt only when flag and enable both set.
// - Flags set regardless of enable bits.
// - Bit 5 gates async advance at threshold.
// - Bit 4 gates system error immediately.
// - Bit 3 gates frame list rollover.
// - Bit 2 gates port change detect.
// - Bit 1 gates transfer error at threshold.
// - Bit 0 gates transfer complete at threshold.
// - Threshold one raises interrupt at once.
// - Index writable only while halted.
// - Index bits N:3 select list entry.
// - N is 12, 11, 10 per size.
// - Base keeps bits 31:12, low bits zero.
// - Status flags clear on write one.
// - Size code selects 1024, 512, 256 entries.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "uhie_defines.vh"

module uhie_regs #(
  parameter integer UFRAME_CYCLES = `UHIE_UFRAME_CYCLES
) (
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire transferDone,
  input wire transferError,
  input wire portChange,
  input wire systemError,
  input wire asyncAdvance,
  output reg interruptOut,
  output reg [9:0] frameListEntry,
  output reg [31:0] frameEntryAddress,
  output reg controllerHalted
);

  reg [`UHIE_EV_COUNT-1:0] interruptEnable;
  reg [`UHIE_FRAME_INDEX_W-1:0] frameIndex;
  reg [31:`UHIE_BASE_LSB] periodicBase;
  reg runStop;
  reg [1:0] listSize;
  reg [`UHIE_CTL_THR_W-1:0] threshold;
  reg [`UHIE_CTL_THR_W-1:0] thresholdCount;
  reg thresholdDue;
  wire [`UHIE_EV_COUNT-1:0] eventFlag;
  wire [`UHIE_EV_COUNT-1:0] setEvent;
  wire [`UHIE_EV_COUNT-1:0] clearEvent;
  wire uframeTick;
  wire rolloverEvent;
  wire [`UHIE_FRAME_INDEX_W-1:0] next_frameIndex;
  reg [9:0] next_entry;
  reg entryWrap;
  reg [`UHIE_EV_COUNT-1:0] pending;
  reg next_interrupt;
  reg [31:0] readValue;
  reg addrHit;

  wire access = psel && penable;
  wire writeAccess = access && pwrite;
  wire statusWrite = writeAccess && (paddr == `UHIE_STATUS_ADDR);
  // A write lands on the access edge, while pready stands high.
  wire writeLands = writeAccess && pready;
  wire enableWrite = writeLands && (paddr == `UHIE_INTR_EN_ADDR);
  wire indexWrite = writeLands && (paddr == `UHIE_FRAME_INDEX_ADDR);
  wire baseWrite = writeLands && (paddr == `UHIE_PLIST_BASE_ADDR);
  wire controlWrite = writeLands && (paddr == `UHIE_CONTROL_ADDR);

  // One tick per micro-frame; it restarts whenever the run bit drops.
  uhie_uframe_timer #(
    .CYCLES(UFRAME_CYCLES)
  ) uframeTimer (
    .clock(clock),
    .rst_b(rst_b),
    .running(runStop),
    .tick(uframeTick)
  );

  assign next_frameIndex = frameIndex + 14'h0001;

  // Entry index width depends on list size; wrap of it is the rollover.
  always @* begin
    next_entry = 10'h000;
    entryWrap = 1'b0;
    case (listSize)
      `UHIE_SIZE_1024: begin
        next_entry = frameIndex[12:3];
        entryWrap = (frameIndex[12:0] == 13'h1fff);
      end
      `UHIE_SIZE_512: begin
        next_entry = {1'b0, frameIndex[11:3]};
        entryWrap = (frameIndex[11:0] == 12'hfff);
      end
      `UHIE_SIZE_256: begin
        next_entry = {2'b00, frameIndex[10:3]};
        entryWrap = (frameIndex[10:0] == 11'h7ff);
      end
      default: begin
        next_entry = frameIndex[12:3];
        entryWrap = 1'b0;
      end
    endcase
  end

  assign rolloverEvent = uframeTick && entryWrap;

  // Event inputs always set their flags, independent of the enables.
  assign setEvent[`UHIE_EV_XFER_DONE] = transferDone;
  assign setEvent[`UHIE_EV_XFER_ERR] = transferError;
  assign setEvent[`UHIE_EV_PORT_CHG] = portChange;
  assign setEvent[`UHIE_EV_ROLLOVER] = rolloverEvent;
  assign setEvent[`UHIE_EV_SYS_ERR] = systemError;
  assign setEvent[`UHIE_EV_ASYNC_ADV] = asyncAdvance;
  assign clearEvent = statusWrite ? pwdata[`UHIE_EV_COUNT-1:0] :
    {`UHIE_EV_COUNT{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `UHIE_EV_COUNT; gi = gi + 1) begin : evFlag
      uhie_event_flag flagCell (
        .clock(clock),
        .rst_b(rst_b),
        .setEvent(setEvent[gi]),
        .clearEvent(clearEvent[gi]),
        .flag(eventFlag[gi])
      );
    end
  endgenerate

  // Threshold events wait for the threshold boundary, counted in
  // micro-frames; a threshold of one (or zero) passes them at once.
  // The count only moves while ticks arrive, so a halted controller
  // holds threshold events back until the threshold is set to one or zero.
  wire thresholdOpen = (threshold <= 8'h01);
  wire boundaryTick = uframeTick &&
    (thresholdCount >= threshold - 8'h01);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      thresholdCount <= 8'h00;
    end else if (thresholdOpen || boundaryTick) begin
      thresholdCount <= 8'h00;
    end else if (uframeTick) begin
      thresholdCount <= thresholdCount + 8'h01;
    end
  end

  // The boundary flag lasts one cycle unless the line is already up.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      thresholdDue <= 1'b0;
    end else if (thresholdOpen || boundaryTick) begin
      thresholdDue <= 1'b1;
    end else if (thresholdDue && !interruptOut) begin
      thresholdDue <= 1'b0;
    end
  end

  always @* begin
    pending = eventFlag & interruptEnable;
    next_interrupt = 1'b0;
    // System error, rollover and port change skip the threshold.
    if (pending[`UHIE_EV_SYS_ERR]) begin
      next_interrupt = 1'b1;
    end
    if (pending[`UHIE_EV_ROLLOVER]) begin
      next_interrupt = 1'b1;
    end
    if (pending[`UHIE_EV_PORT_CHG]) begin
      next_interrupt = 1'b1;
    end
    // Once raised, the line stays up until software clears the flags,
    // so the threshold only delays the rising edge.
    if (thresholdDue || interruptOut) begin
      if (pending[`UHIE_EV_ASYNC_ADV]) begin
        next_interrupt = 1'b1;
      end
      if (pending[`UHIE_EV_XFER_ERR]) begin
        next_interrupt = 1'b1;
      end
      if (pending[`UHIE_EV_XFER_DONE]) begin
        next_interrupt = 1'b1;
      end
    end
  end

  // Reserved bits and unmapped offsets read as zero.
  always @* begin
    readValue = 32'h00000000;
    addrHit = 1'b1;
    case (paddr)
      `UHIE_STATUS_ADDR: begin
        readValue[`UHIE_EV_COUNT-1:0] = eventFlag;
        readValue[`UHIE_HALTED_BIT] = ~runStop;
      end
      `UHIE_INTR_EN_ADDR: begin
        readValue[`UHIE_EV_COUNT-1:0] = interruptEnable;
      end
      `UHIE_FRAME_INDEX_ADDR: begin
        readValue[`UHIE_FRAME_INDEX_W-1:0] = frameIndex;
      end
      `UHIE_PLIST_BASE_ADDR: begin
        readValue[31:`UHIE_BASE_LSB] = periodicBase;
      end
      `UHIE_CONTROL_ADDR: begin
        readValue[`UHIE_CTL_RUN_BIT] = runStop;
        readValue[`UHIE_CTL_SIZE_LSB+1:`UHIE_CTL_SIZE_LSB] = listSize;
        readValue[`UHIE_CTL_THR_LSB+`UHIE_CTL_THR_W-1:`UHIE_CTL_THR_LSB] =
          threshold;
      end
      default: begin
        readValue = 32'h00000000;
        addrHit = 1'b0;
      end
    endcase
  end

  // Zero wait states: every access completes in its first access cycle.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrHit;
      if (psel && !penable && !pwrite) begin
        prdata <= readValue;
      end
    end
  end

  // Each register has its own process, so a write to one of them never
  // holds back the hardware update of another.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      interruptEnable <= `UHIE_ENABLE_RESET;
    end else if (enableWrite) begin
      interruptEnable <= pwdata[`UHIE_EV_COUNT-1:0];
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      periodicBase <= `UHIE_BASE_RESET;
    end else if (baseWrite) begin
      periodicBase <= pwdata[31:`UHIE_BASE_LSB];
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      runStop <= `UHIE_RUN_RESET;
      listSize <= `UHIE_SIZE_1024;
      threshold <= `UHIE_THR_RESET;
    end else if (controlWrite) begin
      runStop <= pwdata[`UHIE_CTL_RUN_BIT];
      listSize <= pwdata[`UHIE_CTL_SIZE_LSB+1:`UHIE_CTL_SIZE_LSB];
      threshold <=
        pwdata[`UHIE_CTL_THR_LSB+`UHIE_CTL_THR_W-1:`UHIE_CTL_THR_LSB];
    end
  end

  // Writes while running are dropped so software cannot skew the
  // schedule under the controller's feet. A dropped write must not
  // swallow a micro-frame tick that falls in the same cycle.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frameIndex <= `UHIE_FRAME_INDEX_RESET;
    end else if (indexWrite && !runStop) begin
      frameIndex <= pwdata[`UHIE_FRAME_INDEX_W-1:0];
    end else if (uframeTick && runStop) begin
      frameIndex <= next_frameIndex;
    end
  end

  // The line is registered so flag updates never make it glitch.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      interruptOut <= 1'b0;
    end else begin
      interruptOut <= next_interrupt;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frameListEntry <= 10'h000;
      frameEntryAddress <= 32'h00000000;
      controllerHalted <= 1'b1;
    end else begin
      frameListEntry <= next_entry;
      frameEntryAddress <= {periodicBase, next_entry, 2'b00};
      controllerHalted <= ~runStop;
    end
  end

endmodule

// *** hw/uhie_uframe_timer.v ***
`timescale 1ns/10ps
`include "uhie_defines.vh"

module uhie_uframe_timer #(
  parameter integer CYCLES = `UHIE_UFRAME_CYCLES
) (
  input wire clock,
  input wire rst_b,
  input wire running,
  output reg tick
);

  reg [31:0] count;

  // Counter restarts whenever the controller stops, so each run begins
  // with a full micro-frame.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else if (!running) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else if (count == CYCLES - 1) begin
      count <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick <= 1'b0;
    end
  end

endmodule

// *** verif/uhie_apb_host.sv ***
`timescale 1ns/10ps
module uhie_apb_host (
  input wire clock,
  output reg psel,
  output reg penable,
  output reg pwrite,
  output reg [11:0] paddr,
  output reg [31:0] pwdata,
  input wire pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // The request stays put until pready is seen, never a fixed count.
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (!pready) @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
    end
  endtask
endmodule

// *** verif/uhie_regs_checker.sv ***
`timescale 1ns/10ps
module uhie_regs_checker (
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire portChange,
  input wire systemError,
  input wire interruptOut,
  input wire [9:0] frameListEntry,
  input wire [31:0] frameEntryAddress
);
  reg [5:0] en;
  reg [19:0] base;
  wire done = psel && penable && pready;
  wire rd = done && !pwrite;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Enable bits and list base are mirrored so checks know what to expect.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en <= 6'h00;
      base <= 20'h00000;
    end else if (done && pwrite) begin
      if (paddr == 12'h018) begin
        en <= pwdata[5:0];
      end
      if (paddr == 12'h024) begin
        base <= pwdata[31:12];
      end
    end
  end
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_index_high: assert property (
    rd && paddr == 12'h01c |-> prdata[31:14] == 18'h0)
    else $error("index upper bits set");
  chk_base_low: assert property (
    rd && paddr == 12'h024 |-> prdata[11:0] == 12'h000)
    else $error("base low bits set");
  chk_enable_rsvd: assert property (
    rd && paddr == 12'h018 |-> prdata[31:6] == 26'h0)
    else $error("enable reserved bits set");
  chk_sys_irq: assert property (
    systemError && en[4] |-> ##[1:4] interruptOut)
    else $error("system error gave no interrupt");
  chk_port_irq: assert property (
    portChange && en[2] |-> ##[1:4] interruptOut)
    else $error("port change gave no interrupt");
  chk_irq_masked: assert property (
    (en == 6'h00) [*3] |-> !interruptOut)
    else $error("interrupt with all enables off");
  chk_entry_addr: assert property (
    $stable(frameListEntry) [*2] |->
      frameEntryAddress[11:0] == {frameListEntry, 2'b00})
    else $error("entry address mismatch");
  chk_entry_base: assert property (
    $stable(base) |-> frameEntryAddress[31:12] == base)
    else $error("entry address base mismatch");
endmodule
bind uhie_regs uhie_regs_checker u_chk (.*);

// *** verif/usb_host_irq_enable_frame_index_bench.sv ***
`timescale 1ns/10ps
module usb_host_irq_enable_frame_index_bench;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg [4:0] ev = 5'h00;
  wire psel, penable, pwrite, pready, pslverr, interruptOut, halted;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata, frameEntryAddress;
  wire [9:0] frameListEntry;
  reg [32:0] notes[$];
  reg [31:0] r;
  integer nMismatch = 0;
  integer samplesChecked = 0;
  integer seed = 60;
  integer cyc = 0;
  integer i, n;
  always #2.5 clock = ~clock;
  uhie_apb_host u_host (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
  uhie_regs #(.UFRAME_CYCLES(20)) u_dut (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transferDone(ev[0]), .transferError(ev[1]), .portChange(ev[2]),
    .systemError(ev[3]), .asyncAdvance(ev[4]), .interruptOut(interruptOut),
    .frameListEntry(frameListEntry), .frameEntryAddress(frameEntryAddress),
    .controllerHalted(halted));
  task cmp(input [32:0] got, input [32:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
        nMismatch = nMismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checked=%0d mismatches=%0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task rd(input [11:0] a, input [32:0] e);
    begin
      notes.push_back(e);
      u_host.xfer(1'b0, a, 32'h0);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task pulse(input integer k);
    begin
      @(posedge clock);
      ev[k] <= 1'b1;
      @(posedge clock);
      ev <= 5'h00;
    end
  endtask
  task irq(input e);
    begin
      repeat (4) @(posedge clock);
      cmp({32'h0, interruptOut}, {32'h0, e});
    end
  endtask
  // Each read answer is matched against the oldest noted expectation.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nMismatch = nMismatch + 1;
      summarize;
    end
    if (psel && penable && pready && !pwrite)
      cmp({pslverr, prdata}, notes.pop_front());
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rd(12'h018, 33'h0);
    rd(12'h01c, 33'h0);
    rd(12'h024, 33'h0);
    rd(12'h014, 33'h1000);
    rd(12'h008, 33'h100000000);
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      wr(12'h018, r);
      rd(12'h018, {27'h0, r[5:0]});
      wr(12'h01c, r);
      rd(12'h01c, {19'h0, r[13:0]});
      wr(12'h024, r);
      rd(12'h024, {1'b0, r[31:12], 12'h000});
    end
    wr(12'h018, 32'h0);
    for (i = 0; i < 5; i = i + 1) pulse(i);
    rd(12'h014, 33'h1037);
    wr(12'h014, 32'h5);
    rd(12'h014, 33'h1032);
    wr(12'h014, 32'h3f);
    wr(12'h018, 32'h1);
    pulse(0);
    irq(1'b0);
    wr(12'h040, 32'h10000);
    irq(1'b1);
    wr(12'h014, 32'h1);
    for (i = 0; i < 5; i = i + 1) begin
      n = i + (i > 2);
      wr(12'h018, 32'h1 << n);
      pulse(i);
      irq(1'b1);
      wr(12'h014, 32'h1 << n);
      irq(1'b0);
    end
    wr(12'h018, 32'h8);
    for (i = 0; i < 3; i = i + 1) begin
      wr(12'h014, 32'h3f);
      wr(12'h01c, (32'h2000 >> i) - 32'h8);
      wr(12'h040, 32'h10001 | (i << 2));
      wr(12'h01c, 32'h3ff8);
      n = 0;
      while (frameListEntry !== 10'h000 && n < 400) begin
        @(posedge clock);
        n = n + 1;
      end
      cmp({32'h0, halted}, 33'h0);
      wr(12'h040, 32'h10000 | (i << 2));
      rd(12'h01c, 33'h2000 >> i);
      rd(12'h014, 33'h1008);
      cmp({32'h0, halted}, 33'h1);
      cmp({1'b0, frameEntryAddress}, {1'b0, r[31:12], 12'h000});
    end
    irq(1'b1);
    summarize;
  end
endmodule
